/* rtl/ccr_top.sv */
// clock control and i/o port reset registers behind an ahb-lite slave
`timescale 1ns/100ps
module ccr_top
  import ccr_pkg::*;
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_B,
  // ahb-lite slave
  input  wire logic        I_HSEL,
  input  wire logic [31:0] I_HADDR,
  input  wire logic [1:0]  I_HTRANS,
  input  wire logic        I_HWRITE,
  input  wire logic [2:0]  I_HSIZE,
  input  wire logic        I_HREADY,
  input  wire logic [31:0] I_HWDATA,
  output logic      [31:0] O_HRDATA,
  output logic             O_HREADYOUT,
  output logic             O_HRESP,
  // port resets
  output logic             O_PORT_A_RESET_REQ,
  output logic             O_PORT_B_RESET_REQ,
  output logic             O_PORT_C_RESET_REQ,
  output logic             O_PORT_D_RESET_REQ,
  // oscillator and pll controls
  output logic             O_FAST_INT_OSC_ON,
  output logic             O_FAST_EXT_OSC_ON,
  output logic             O_SLOW_INT_OSC_ON,
  output logic             O_SLOW_EXT_OSC_ON,
  output logic             O_PLL_ON,
  output logic             O_FAST_INT_OSC_FILTER_BYPASS,
  output logic             O_FAST_EXT_OSC_BYPASS,
  output logic      [2:0]  O_SLOW_EXT_OSC_DRIVE,
  // clock tree settings
  output ccr_tree_s        O_TREE,
  output logic             O_APPLY_CLOCK_CHANGE
);

  ccr_phase_e             phase_q;    // pending data phase
  ccr_phase_e             phase_d;
  ccr_req_s               req_q;      // latched address phase
  ccr_req_s               req_d;
  logic [CCR_PRST_W-1:0]  prst_q;     // port reset requests
  logic [CCR_PRST_W-1:0]  prst_d;
  logic [31:0]            osc_q;      // oscillator control
  logic [31:0]            osc_d;
  logic [31:0]            cfg_q;      // clock tree configuration
  logic [31:0]            cfg_d;
  logic                   apply_q;    // apply strobe
  logic                   apply_d;
  logic [31:0]            rdata_q;    // read data
  logic [31:0]            rdata_d;
  logic                   take;       // address phase accepted
  logic [31:0]            cfg_mask;   // writable configuration bits

  // address phase is taken when selected, nonseq and bus ready
  assign take = I_HSEL && I_HREADY && (I_HTRANS == CCR_HTRANS_NONSEQ);

  // pll fields locked while pll runs
  always_comb begin
    if (osc_q[CCR_OSC_PLL_ON]) begin
      cfg_mask = CCR_CFG_FREE_MASK;
    end else begin
      cfg_mask = CCR_CFG_FREE_MASK | CCR_CFG_PLL_MASK;
    end
  end

  // bus phase tracking and register writes
  always_comb begin
    phase_d = phase_q;
    req_d   = req_q;
    prst_d  = prst_q;
    osc_d   = osc_q;
    cfg_d   = cfg_q;
    apply_d = 1'b0;
    rdata_d = rdata_q;
    // data phase of a write stores hwdata
    if (phase_q == CCR_WR) begin
      if (req_q.addr == CCR_OFS_PORT_RST) begin
        prst_d = I_HWDATA[CCR_PRST_W-1:0];
      end else if (req_q.addr == CCR_OFS_OSC_CTRL) begin
        osc_d = I_HWDATA & CCR_OSC_WMASK;
      end else if (req_q.addr == CCR_OFS_TREE_CFG) begin
        cfg_d   = (cfg_q & ~cfg_mask) | (I_HWDATA & cfg_mask);
        apply_d = I_HWDATA[CCR_CFG_APPLY];
      end
    end
    // new address phase
    if (take) begin
      req_d.addr  = I_HADDR[7:0];
      req_d.write = I_HWRITE;
      if (I_HWRITE) begin
        phase_d = CCR_WR;
      end else begin
        phase_d = CCR_RD;
        // read data for the latched address goes out in the data phase
      end
    end else begin
      phase_d = CCR_IDLE;
    end
    // capture read data at address phase end
    if (take && !I_HWRITE) begin
      if (I_HADDR[7:0] == CCR_OFS_PORT_RST) begin
        rdata_d = {28'h0000000, prst_d};
      end else if (I_HADDR[7:0] == CCR_OFS_OSC_CTRL) begin
        rdata_d = osc_d;
      end else if (I_HADDR[7:0] == CCR_OFS_TREE_CFG) begin
        rdata_d = cfg_d;
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  // register all state
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      phase_q <= CCR_IDLE;
      req_q   <= '0;
      prst_q  <= CCR_PRST_RST;
      osc_q   <= CCR_OSC_RST;
      cfg_q   <= CCR_CFG_RST;
      apply_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      phase_q <= phase_d;
      req_q   <= req_d;
      prst_q  <= prst_d;
      osc_q   <= osc_d;
      cfg_q   <= cfg_d;
      apply_q <= apply_d;
      rdata_q <= rdata_d;
    end
  end

  // zero wait state slave, always okay
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;
  assign O_HRDATA    = rdata_q;

  // oscillator and pll control outputs straight from the register
  assign O_FAST_INT_OSC_ON            = osc_q[CCR_OSC_FINT_ON];
  assign O_FAST_EXT_OSC_ON            = osc_q[CCR_OSC_FEXT_ON];
  assign O_SLOW_INT_OSC_ON            = osc_q[CCR_OSC_SINT_ON];
  assign O_SLOW_EXT_OSC_ON            = osc_q[CCR_OSC_SEXT_ON];
  assign O_PLL_ON                     = osc_q[CCR_OSC_PLL_ON];
  assign O_FAST_INT_OSC_FILTER_BYPASS = osc_q[CCR_OSC_FINT_BYP];
  assign O_FAST_EXT_OSC_BYPASS        = osc_q[CCR_OSC_FEXT_BYP];
  assign O_SLOW_EXT_OSC_DRIVE         = osc_q[CCR_OSC_DRV_MSB:CCR_OSC_DRV_LSB];
  assign O_APPLY_CLOCK_CHANGE         = apply_q;

  // port reset lines
  logic [CCR_PRST_W-1:0] port_rst;  // registered reset lines
  ccr_port_reset u_port_reset (
    .i_clk      (I_CLK_SYS),
    .i_rst_b    (I_RST_B),
    .i_req      (prst_q),
    .o_port_rst (port_rst)
  );
  assign O_PORT_A_RESET_REQ = port_rst[CCR_PRST_A];
  assign O_PORT_B_RESET_REQ = port_rst[CCR_PRST_B];
  assign O_PORT_C_RESET_REQ = port_rst[CCR_PRST_C];
  assign O_PORT_D_RESET_REQ = port_rst[CCR_PRST_D];

  // clock tree decode
  ccr_tree_decode u_tree (
    .i_clk   (I_CLK_SYS),
    .i_rst_b (I_RST_B),
    .i_cfg   (cfg_q),
    .o_tree  (O_TREE)
  );

endmodule

/* include/ccr_pkg.sv */
// package with register map, field layout and reset values of the clock and port reset block
package ccr_pkg;

  // register byte offsets
  localparam logic [7:0] CCR_OFS_PORT_RST = 8'h2c;  // fast_bus_port_reset_request
  localparam logic [7:0] CCR_OFS_OSC_CTRL = 8'h30;  // oscillator_enable_control
  localparam logic [7:0] CCR_OFS_TREE_CFG = 8'h34;  // clock_tree_configuration

  // port reset request fields
  localparam int CCR_PRST_A   = 0;                  // port a reset request
  localparam int CCR_PRST_B   = 1;                  // port b reset request
  localparam int CCR_PRST_C   = 2;                  // port c reset request
  localparam int CCR_PRST_D   = 3;                  // port d reset request
  localparam int CCR_PRST_W   = 4;                  // stored width
  localparam logic [3:0] CCR_PRST_RST = 4'h0;       // reset value

  // oscillator control fields
  localparam int CCR_OSC_FINT_ON  = 0;              // fast internal osc on
  localparam int CCR_OSC_FEXT_ON  = 1;              // fast external osc on
  localparam int CCR_OSC_SINT_ON  = 2;              // slow internal osc on
  localparam int CCR_OSC_SEXT_ON  = 3;              // slow external osc on
  localparam int CCR_OSC_PLL_ON   = 4;              // pll on
  localparam int CCR_OSC_FINT_BYP = 8;              // fast internal filter bypass
  localparam int CCR_OSC_FEXT_BYP = 9;              // fast external bypass
  localparam int CCR_OSC_DRV_LSB  = 10;             // slow ext drive low bit
  localparam int CCR_OSC_DRV_MSB  = 12;             // slow ext drive high bit
  localparam logic [31:0] CCR_OSC_WMASK = 32'h0000_1f1f; // writable bits
  localparam logic [31:0] CCR_OSC_RST   = 32'h0000_0701; // reset value

  // clock tree configuration fields
  localparam int CCR_CFG_SRC_LSB  = 0;              // system clock source
  localparam int CCR_CFG_SRC_MSB  = 1;
  localparam int CCR_CFG_FDIV_LSB = 4;              // fast bus divider
  localparam int CCR_CFG_FDIV_MSB = 7;
  localparam int CCR_CFG_PDIV_LSB = 8;              // periph bus divider
  localparam int CCR_CFG_PDIV_MSB = 10;
  localparam int CCR_CFG_XDIV_LSB = 12;             // ext predivider
  localparam int CCR_CFG_XDIV_MSB = 13;
  localparam int CCR_CFG_PSRC     = 16;             // pll input source
  localparam int CCR_CFG_MUL_LSB  = 17;             // pll multiplier
  localparam int CCR_CFG_MUL_MSB  = 21;
  localparam int CCR_CFG_OSEL_LSB = 24;             // clock out select
  localparam int CCR_CFG_OSEL_MSB = 26;
  localparam int CCR_CFG_ODIV_LSB = 28;             // clock out divider
  localparam int CCR_CFG_ODIV_MSB = 30;
  localparam int CCR_CFG_APPLY    = 31;             // write-only apply strobe
  localparam logic [31:0] CCR_CFG_FREE_MASK = 32'h7700_07f3; // always writable
  localparam logic [31:0] CCR_CFG_PLL_MASK  = 32'h003f_3000; // only with pll off
  localparam logic [31:0] CCR_CFG_RST       = 32'h0000_0000; // reset value

  // decoded codes
  localparam logic [1:0] CCR_SRC_FINT = 2'h0;       // fast internal oscillator
  localparam logic [1:0] CCR_SRC_FEXT = 2'h1;       // divided fast external
  localparam logic [1:0] CCR_SRC_PLL  = 2'h2;       // pll
  localparam logic [3:0] CCR_FDIV_MIN = 4'h8;       // first dividing fast code
  localparam logic [3:0] CCR_FDIV_MAX = 4'hb;       // last dividing fast code
  localparam logic [2:0] CCR_PDIV_MIN = 3'h4;       // first dividing periph code

  // ahb transfer type
  localparam logic [1:0] CCR_HTRANS_NONSEQ = 2'h2;

  // bus access phase state
  typedef enum logic [1:0] {CCR_IDLE, CCR_WR, CCR_RD} ccr_phase_e;

  // latched address phase
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
  } ccr_req_s;

  // clock tree settings as seen by the clock generators
  typedef struct packed {
    logic [1:0] sys_src;    // system clock source, 3 reserved
    logic [4:0] fast_log2;  // fast bus divide as power of two
    logic [4:0] periph_log2;// periph bus divide as power of two
    logic [1:0] ext_prediv; // ext predivider code
    logic       pll_src;    // pll input source
    logic [4:0] pll_mul;    // pll multiplier
    logic [2:0] out_sel;    // clock out select
    logic [2:0] out_div;    // clock out divider
  } ccr_tree_s;

endpackage

/* rtl/ccr_port_reset.sv */
// registered reset outputs to the four i/o ports
`timescale 1ns/100ps
module ccr_port_reset
  import ccr_pkg::*;
(
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_b,
  input  wire logic [CCR_PRST_W-1:0]  i_req,
  output logic      [CCR_PRST_W-1:0]  o_port_rst
);

  logic [CCR_PRST_W-1:0] rst_q;  // registered reset lines
  logic [CCR_PRST_W-1:0] rst_d;

  // each line follows its stored request bit
  always_comb begin
    rst_d = i_req;
  end

  // register the lines
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_q <= CCR_PRST_RST;
    end else begin
      rst_q <= rst_d;
    end
  end

  assign o_port_rst = rst_q;

endmodule

/* rtl/ccr_tree_decode.sv */
// decodes the configuration register into registered clock tree settings
`timescale 1ns/100ps
module ccr_tree_decode
  import ccr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [31:0] i_cfg,
  output ccr_tree_s        o_tree
);

  // fast bus code to log2 divide, reserved codes pass undivided
  function automatic logic [4:0] fast_log2(input logic [3:0] code);
    if (code >= CCR_FDIV_MIN && code <= CCR_FDIV_MAX) begin
      fast_log2 = 5'(code - CCR_FDIV_MIN) + 5'h1;
    end else begin
      fast_log2 = 5'h0;
    end
  endfunction

  // periph bus code to log2 divide
  function automatic logic [4:0] periph_log2(input logic [2:0] code);
    if (code >= CCR_PDIV_MIN) begin
      periph_log2 = 5'(code - CCR_PDIV_MIN) + 5'h1;
    end else begin
      periph_log2 = 5'h0;
    end
  endfunction

  ccr_tree_s tree_q;  // registered settings
  ccr_tree_s tree_d;

  // field extraction
  always_comb begin
    tree_d             = tree_q;
    tree_d.sys_src     = i_cfg[CCR_CFG_SRC_MSB:CCR_CFG_SRC_LSB];
    tree_d.fast_log2   = fast_log2(i_cfg[CCR_CFG_FDIV_MSB:CCR_CFG_FDIV_LSB]);
    tree_d.periph_log2 = periph_log2(i_cfg[CCR_CFG_PDIV_MSB:CCR_CFG_PDIV_LSB]);
    tree_d.ext_prediv  = i_cfg[CCR_CFG_XDIV_MSB:CCR_CFG_XDIV_LSB];
    tree_d.pll_src     = i_cfg[CCR_CFG_PSRC];
    tree_d.pll_mul     = i_cfg[CCR_CFG_MUL_MSB:CCR_CFG_MUL_LSB];
    tree_d.out_sel     = i_cfg[CCR_CFG_OSEL_MSB:CCR_CFG_OSEL_LSB];
    tree_d.out_div     = i_cfg[CCR_CFG_ODIV_MSB:CCR_CFG_ODIV_LSB];
  end

  // register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tree_q <= '0;
    end else begin
      tree_q <= tree_d;
    end
  end

  assign o_tree = tree_q;

endmodule

/* verif/ccr_top_sva.sv */
// assertion checker for the clock and port reset register block
`timescale 1ns/100ps
module ccr_top_sva
  import ccr_pkg::*;
(
  input wire logic        I_CLK_SYS,
  input wire logic        I_RST_B,
  input wire logic        I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0]  I_HTRANS,
  input wire logic        I_HWRITE,
  input wire logic        I_HREADY,
  input wire logic [31:0] I_HWDATA,
  input wire logic [31:0] O_HRDATA,
  input wire logic        O_PORT_A_RESET_REQ,
  input wire logic        O_PORT_B_RESET_REQ,
  input wire logic        O_PORT_C_RESET_REQ,
  input wire logic        O_PORT_D_RESET_REQ,
  input wire logic        O_PLL_ON,
  input wire ccr_tree_s   O_TREE,
  input wire logic        O_APPLY_CLOCK_CHANGE
);
  default clocking @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);
  logic       tk_q;  // transfer taken at last edge
  logic       wr_q;  // it was a write
  logic [7:0] ad_q;  // its decoded address
  // remember the address phase so the data phase can be judged
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tk_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 8'h00;
    end else begin
      tk_q <= I_HSEL & I_HREADY & (I_HTRANS == CCR_HTRANS_NONSEQ);
      wr_q <= I_HWRITE;
      ad_q <= I_HADDR[7:0];
    end
  end
  wire logic       w_prst = tk_q & wr_q & (ad_q == CCR_OFS_PORT_RST);  // data phase kinds
  wire logic       r_prst = tk_q & !wr_q & (ad_q == CCR_OFS_PORT_RST);
  wire logic       w_osc  = tk_q & wr_q & (ad_q == CCR_OFS_OSC_CTRL);
  wire logic       w_cfg  = tk_q & wr_q & (ad_q == CCR_OFS_TREE_CFG);
  wire logic       ap_c   = w_cfg & I_HWDATA[31];  // apply request
  wire logic [3:0] prt    = {O_PORT_D_RESET_REQ, O_PORT_C_RESET_REQ,
                             O_PORT_B_RESET_REQ, O_PORT_A_RESET_REQ};
  wire logic [7:0] pll_f  = {O_TREE.ext_prediv, O_TREE.pll_src, O_TREE.pll_mul};
  wire logic [7:0] pll_w  = {I_HWDATA[13:12], I_HWDATA[16], I_HWDATA[21:17]};
  // expected divider exponents from the written codes
  wire logic [4:0] f_exp  = (I_HWDATA[7:4] >= 4'h8 && I_HWDATA[7:4] <= 4'hb) ?
                            5'(I_HWDATA[7:4] - 4'h7) : 5'h0;
  wire logic [4:0] p_exp  = I_HWDATA[10] ? 5'(I_HWDATA[10:8] - 3'h3) : 5'h0;

  property p_port_follow; w_prst |-> ##2 (prt == $past(I_HWDATA[3:0], 2)); endproperty
  a_port_follow: assert property (p_port_follow)
    else $error("port reset outputs differ from written bits");
  property p_port_hold; $changed(prt) |-> $past(w_prst, 2); endproperty
  a_port_hold: assert property (p_port_hold)
    else $error("port reset changed without a write");
  property p_prst_read; r_prst |-> (O_HRDATA[31:4] == 28'h0); endproperty
  a_prst_read: assert property (p_prst_read)
    else $error("port reset upper bits not zero");
  property p_pll_on; w_osc |=> (O_PLL_ON == $past(I_HWDATA[4])); endproperty
  a_pll_on: assert property (p_pll_on)
    else $error("pll enable differs from written bit");
  property p_tree_div;
    w_cfg |-> ##2 (O_TREE.sys_src == $past(I_HWDATA[1:0], 2) &&
      O_TREE.fast_log2 == $past(f_exp, 2) && O_TREE.periph_log2 == $past(p_exp, 2));
  endproperty
  a_tree_div: assert property (p_tree_div)
    else $error("clock source or divider decode wrong");
  property p_pll_lock; w_cfg && O_PLL_ON |-> ##2 (pll_f == $past(pll_f, 2)); endproperty
  a_pll_lock: assert property (p_pll_lock)
    else $error("pll fields changed while pll on");
  property p_pll_free; w_cfg && !O_PLL_ON |-> ##2 (pll_f == $past(pll_w, 2)); endproperty
  a_pll_free: assert property (p_pll_free)
    else $error("pll fields not taken while pll off");
  property p_apply; (O_APPLY_CLOCK_CHANGE == $past(ap_c)); endproperty
  a_apply: assert property (p_apply)
    else $error("apply pulse wrong");
  c_port_all: cover property (w_prst && I_HWDATA[3:0] == 4'hf);
  c_pll_lock: cover property (w_cfg && O_PLL_ON);
  c_apply: cover property (O_APPLY_CLOCK_CHANGE);
endmodule

bind ccr_top ccr_top_sva u_ccr_top_sva (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR),
  .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY), .I_HWDATA(I_HWDATA),
  .O_HRDATA(O_HRDATA), .O_PORT_A_RESET_REQ(O_PORT_A_RESET_REQ),
  .O_PORT_B_RESET_REQ(O_PORT_B_RESET_REQ), .O_PORT_C_RESET_REQ(O_PORT_C_RESET_REQ),
  .O_PORT_D_RESET_REQ(O_PORT_D_RESET_REQ), .O_PLL_ON(O_PLL_ON), .O_TREE(O_TREE),
  .O_APPLY_CLOCK_CHANGE(O_APPLY_CLOCK_CHANGE)
);

/* verif/test_ccr_top.sv */
// self-checking bench for the clock and port reset register block
`timescale 1ns/100ps
module test_ccr_top
  import ccr_pkg::*;
;
  logic        clk = 1'b0;     // system clock
  logic        rst_b = 1'b0;   // active low reset
  logic        hsel = 1'b0;    // bus master drive
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;         // slave answer
  logic        hready;
  logic        hresp;
  wire  [3:0]  prt;            // port reset outputs
  wire  [12:0] osc;            // oscillator outputs as register image
  ccr_tree_s   tree;
  logic        apply;
  logic [31:0] m_prst;         // register model
  logic [31:0] m_osc;
  logic [31:0] m_cfg;
  int          n_fail = 0;
  int          n_checks = 0;
  // free running clock
  always #2 clk = ~clk;
  assign osc[7:5] = 3'h0;
  ccr_top u_ccr_top (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HREADY(hready), .I_HWDATA(hwdata),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .O_PORT_A_RESET_REQ(prt[0]), .O_PORT_B_RESET_REQ(prt[1]), .O_PORT_C_RESET_REQ(prt[2]),
    .O_PORT_D_RESET_REQ(prt[3]), .O_FAST_INT_OSC_ON(osc[0]), .O_FAST_EXT_OSC_ON(osc[1]),
    .O_SLOW_INT_OSC_ON(osc[2]), .O_SLOW_EXT_OSC_ON(osc[3]), .O_PLL_ON(osc[4]),
    .O_FAST_INT_OSC_FILTER_BYPASS(osc[8]), .O_FAST_EXT_OSC_BYPASS(osc[9]),
    .O_SLOW_EXT_OSC_DRIVE(osc[12:10]), .O_TREE(tree), .O_APPLY_CLOCK_CHANGE(apply)
  );
  // compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp=%h got=%h", nm, e, g);
    end
  endtask
  // expected clock tree settings from a stored configuration
  function automatic ccr_tree_s tr(input logic [31:0] c);
    ccr_tree_s t;
    t.sys_src     = c[1:0];
    t.fast_log2   = (c[7:4] >= 4'h8 && c[7:4] <= 4'hb) ? 5'(c[7:4] - 4'h7) : 5'h0;
    t.periph_log2 = c[10] ? 5'(c[10:8] - 3'h3) : 5'h0;
    t.ext_prediv  = c[13:12];
    t.pll_src     = c[16];
    t.pll_mul     = c[21:17];
    t.out_sel     = c[26:24];
    t.out_div     = c[30:28];
    return t;
  endfunction
  // one single ahb-lite transfer, waits for hready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= CCR_HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  // write and update the model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
    if (a == CCR_OFS_PORT_RST) m_prst = d & 32'hf;
    if (a == CCR_OFS_OSC_CTRL) m_osc = d & 32'h1f1f;
    if (a == CCR_OFS_TREE_CFG) m_cfg = (d & 32'h7700_07f3) |
                                       ((m_osc[4] ? m_cfg : d) & 32'h003f_3000);
  endtask
  // read and compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, $urandom, r);
    chk("readback", e, r);
  endtask
  // all registers plus one unmapped place
  task automatic regs();
    rd(CCR_OFS_PORT_RST, m_prst);
    rd(CCR_OFS_OSC_CTRL, m_osc);
    rd(CCR_OFS_TREE_CFG, m_cfg);
    rd(8'h40, 32'h0);
  endtask
  // outputs after the slower registered paths settle
  task automatic outs();
    @(posedge clk);
    #1;
    chk("port_rst", m_prst, 32'(prt));
    chk("osc_ctrl", m_osc, 32'(osc));
    chk("tree", 32'(tr(m_cfg)), 32'(tree));
    chk("apply", 32'h0, 32'(apply));
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    m_prst = 32'h0;
    m_osc  = 32'h701;
    m_cfg  = 32'h0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #50000;
    n_fail++;
    close_out();
  end
  // main sequence, run twice so the second reset lands on written, non-reset register values with the bus idle
  initial begin
    logic [31:0] d;
    void'($urandom(32'h6718506b));
    for (int p = 0; p < 2; p++) begin
      do_reset();
      outs();
      regs();
      $display("reset values done");
      for (int i = 0; i < 12; i++) begin
        wr(CCR_OFS_PORT_RST, (i == 0) ? 32'hffff_ffff : $urandom);
        rd(CCR_OFS_PORT_RST, m_prst);
        outs();
        wr(CCR_OFS_OSC_CTRL, (i == 0) ? 32'hffff_ffff : $urandom);
        rd(CCR_OFS_OSC_CTRL, m_osc);
        outs();
        wr(8'h40, $urandom);
      end
      $display("port and oscillator control done");
      wr(CCR_OFS_OSC_CTRL, 32'h0000_0001);
      for (int i = 0; i < 16; i++) begin
        d = $urandom;
        d[7:4] = i[3:0];
        d[10:8] = i[2:0];
        d[1:0] = i[1:0];
        d[31] = (i == 3);
        wr(CCR_OFS_TREE_CFG, d);
        #1;
        chk("apply_pulse", 32'(d[31]), 32'(apply));
        outs();
        rd(CCR_OFS_TREE_CFG, m_cfg);
      end
      $display("clock tree codes done");
      wr(CCR_OFS_OSC_CTRL, 32'h0000_0011);
      wr(CCR_OFS_TREE_CFG, $urandom | 32'h003f_3000);
      outs();
      regs();
      wr(CCR_OFS_OSC_CTRL, 32'h0000_0001);
      wr(CCR_OFS_TREE_CFG, $urandom & 32'h7fff_ffff);
      outs();
      regs();
      $display("pll field lock done");
    end
    close_out();
  end
endmodule
